// *** include/tcw_regs.vh ***
// Constants for the tightly coupled RAM wrapper.
// Assumes inclusion by bare name from the design files.
`ifndef TCW_REGS_VH
`define TCW_REGS_VH
`define TCW_DATA_W 64
`define TCW_ECC_W 8
`define TCW_BANK_W 36
`define TCW_ADDR_W 12
`define TCW_EV_SERR 0
`define TCW_EV_MERR 1
`define TCW_INIT_ECC 8'h0C
`endif

// *** sim/tb_tcw_wrapper.sv ***
// Bench for the RAM wrapper with a CPU model.
// Assumes AW of 4 for a short auto-initialization.
`timescale 1ns/10ps
`default_nettype none
`include "tcw_regs.vh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin \
    miscompares++; $display("wrong value at %0t: mismatch", $time); end end
module tb_tcw_wrapper;
    localparam int AW = 4;
    typedef struct {logic [3:0] a; logic [63:0] d; logic [7:0] e;} tcw_row_t;
    tcw_row_t rows[4] = '{'{4'h0, 64'h0123_4567_89AB_CDEF, 8'hA5},
        '{4'hF, 64'hFFFF_0000_FFFF_0000, 8'h3C},
        '{4'h5, 64'h8000_0000_0000_0001, 8'hFF}, '{4'hA, 64'h0, 8'h00}};
    logic clk = 0, rst = 1, init_start = 0, serr_clr = 0, merr_clr = 0;
    wire req, wr, apar, rvalid, busy, done, sirq, mirq, sflag, mflag, perr;
    wire derr;
    wire [AW-1:0] addr, saddr, maddr;
    wire [7:0] ben, wecc, recc;
    wire [63:0] wdata, rdata;
    wire [1:0] ev;
    int miscompares = 0, check_count = 0, init_cyc = 0;
    tcw_cpu_model #(.AW(AW)) tcw_cpu_model_i (.clk(clk), .req(req), .wr(wr),
        .addr(addr), .addr_par(apar), .byte_en(ben), .wdata(wdata),
        .wecc(wecc), .ev_bus(ev));
    tcw_wrapper #(.AW(AW)) tcw_wrapper_i (.CLK(clk), .RST(rst), .REQ(req),
        .WR(wr), .ADDR(addr), .ADDR_PAR(apar), .BYTE_EN(ben), .WDATA(wdata),
        .WECC(wecc), .EVENT(ev), .INIT_START(init_start), .RDATA(rdata),
        .RECC(recc), .RVALID(rvalid), .BUSY(busy), .INIT_DONE(done),
        .SERR_IRQ(sirq), .MERR_IRQ(mirq), .SERR_ADDR(saddr), .MERR_ADDR(maddr),
        .SERR_FLAG(sflag), .MERR_FLAG(mflag), .SERR_CLR(serr_clr),
        .MERR_CLR(merr_clr), .PAR_ERR(perr), .DEC_ERR(derr));
    initial forever #25 clk = ~clk;
    task automatic wrap_up;
        $display("comparisons %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic rd(input logic [3:0] a, input logic [63:0] d,
        input logic [7:0] e);
        tcw_cpu_model_i.acc(1'b0, a, 64'h0, 8'h00, 1'b0);
        tcw_cpu_model_i.rel;
        for (int n = 0; n < 6; n++) begin
            @(posedge clk) #1;
            if (rvalid === 1'b1) begin
                `CHK(rdata, d)
                `CHK(recc, e)
                return;
            end
        end
        miscompares++;
        wrap_up;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk) #1;
        `CHK({rvalid, busy, done, sflag, mflag}, 5'h00)
        foreach (rows[i]) tcw_cpu_model_i.acc(1'b1, rows[i].a, rows[i].d,
            rows[i].e, 1'b0);
        tcw_cpu_model_i.rel;
        foreach (rows[i]) rd(rows[i].a, rows[i].d, rows[i].e);
        tcw_cpu_model_i.ev(2'h1);
        #1 `CHK({mirq, sirq, mflag, sflag}, 4'h5)
        tcw_cpu_model_i.ev(2'h2);
        #1 `CHK({mirq, sirq, mflag, sflag}, 4'hB)
        `CHK({saddr, maddr}, {rows[3].a, rows[3].a})
        @(posedge clk) serr_clr <= 1'b1;
        @(posedge clk) serr_clr <= 1'b0;
        #1 `CHK({mflag, sflag}, 2'h2)
        tcw_cpu_model_i.acc(1'b0, 4'h3, 64'h0, 8'h00, 1'b1);
        tcw_cpu_model_i.rel;
        #1 `CHK(perr, 1'b1)
        @(posedge clk) init_start <= 1'b1;
        @(posedge clk) init_start <= 1'b0;
        #1 `CHK(busy, 1'b1)
        for (init_cyc = 0; init_cyc < 40 && busy === 1'b1; init_cyc++)
            @(posedge clk) #1;
        `CHK(init_cyc, 1 << AW)
        `CHK({busy, done}, 2'h1)
        rd(rows[0].a, 64'h0, `TCW_INIT_ECC);
        @(posedge clk) rst <= 1'b1;
        @(posedge clk) rst <= 1'b0;
        #1 `CHK({done, mflag, sirq, perr, derr, rvalid}, 6'h00)
        `CHK({saddr, maddr}, 8'h00)
        wrap_up;
    end
endmodule // tb_tcw_wrapper
`default_nettype wire

// *** sim/tcw_cpu_model.sv ***
// CPU side of the coupled port: requests and event pulses.
// Assumes calls from the bench; drives just after rising edges.
`timescale 1ns/10ps
`default_nettype none
module tcw_cpu_model #(parameter AW = 4) (
    input wire logic clk, // Clock
    output logic req, // Request
    output logic wr, // Write
    output logic [AW-1:0] addr, // Address
    output logic addr_par, // Parity
    output logic [7:0] byte_en, // Byte enables
    output logic [63:0] wdata, // Data
    output logic [7:0] wecc, // ECC
    output logic [1:0] ev_bus // Event bus
);
    initial {req, wr, addr, addr_par, byte_en, wdata, wecc, ev_bus} = '0;
    task automatic acc(input logic w, input logic [AW-1:0] a,
        input logic [63:0] d, input logic [7:0] e, input logic bad);
        @(posedge clk);
        req <= 1'b1;
        wr <= w;
        addr <= a;
        addr_par <= (^a) ^ bad;
        byte_en <= 8'hFF;
        wdata <= d;
        wecc <= e;
    endtask
    // Released address, data and ECC lines show inverted values, not stale ones
    task automatic rel;
        @(posedge clk);
        req <= 1'b0;
        addr <= ~addr;
        wdata <= ~wdata;
        wecc <= ~wecc;
    endtask
    // Event signalling enabled in this CPU
    task automatic ev(input logic [1:0] b);
        @(posedge clk);
        ev_bus <= b;
        @(posedge clk);
        ev_bus <= 2'h0;
    endtask
endmodule // tcw_cpu_model
`default_nettype wire

// *** sim/tcw_wrapper_asserts.sv ***
// Port checker for the RAM wrapper.
// Assumes binding into every tcw_wrapper instance.
`timescale 1ns/10ps
`default_nettype none
module tcw_wrapper_asserts #(parameter AW = 12) (
    input wire CLK, // Clock
    input wire RST, // Reset
    input wire REQ, // Request
    input wire WR, // Write
    input wire [AW-1:0] ADDR, // Address
    input wire ADDR_PAR, // Address parity
    input wire [1:0] EVENT, // Event bus
    input wire SERR_CLR, // Clear
    input wire BUSY, // Init busy
    input wire INIT_DONE, // Init done
    input wire RVALID, // Read valid
    input wire SERR_IRQ, // Single irq
    input wire MERR_IRQ, // Multi irq
    input wire SERR_FLAG, // Single flag
    input wire MERR_FLAG, // Multi flag
    input wire PAR_ERR, // Parity error
    input wire DEC_ERR // Decode error
);
    default clocking dc @(posedge CLK); endclocking
    default disable iff (RST);
    sequence rd_take; REQ && !WR && !BUSY; endsequence
    sequence rd_back; ##2 RVALID; endsequence
    read_answer_a:
    assert property (rd_take |-> rd_back) else $error("read lost");
    write_quiet_a:
    assert property (REQ && WR && !BUSY |-> ##2 !RVALID) else $error("wr");
    serr_irq_a:
    assert property (EVENT[0] |=> SERR_IRQ && SERR_FLAG) else $error("s");
    merr_irq_a:
    assert property (EVENT[1] |=> MERR_IRQ && MERR_FLAG) else $error("m");
    irq_cause_a:
    assert property (SERR_IRQ |-> $past(EVENT[0])) else $error("stray");
    serr_clear_a:
    assert property (SERR_CLR && !EVENT[0] |=> !SERR_FLAG) else $error("c");
    addr_parity_a:
    assert property (REQ && !BUSY && ^{ADDR, ADDR_PAR} |=> PAR_ERR)
        else $error("parity missed");
    init_end_a:
    assert property ($fell(BUSY) |-> INIT_DONE) else $error("init");
    merr_cause_a:
    assert property (!EVENT[1] |=> !MERR_IRQ) else $error("stray multi irq");
    parity_cause_a:
    assert property (!(REQ && !BUSY && ^{ADDR, ADDR_PAR}) |=> !PAR_ERR)
        else $error("parity error without cause");
    decode_same_a:
    assert property (!DEC_ERR) else $error("decode mismatch");
endmodule // tcw_wrapper_asserts
bind tcw_wrapper tcw_wrapper_asserts #(.AW(AW)) tcw_wrapper_asserts_i (
    .CLK(CLK), .RST(RST), .REQ(REQ), .WR(WR), .ADDR(ADDR),
    .ADDR_PAR(ADDR_PAR), .EVENT(EVENT), .SERR_CLR(SERR_CLR), .BUSY(BUSY),
    .INIT_DONE(INIT_DONE), .RVALID(RVALID), .SERR_IRQ(SERR_IRQ),
    .MERR_IRQ(MERR_IRQ), .SERR_FLAG(SERR_FLAG), .MERR_FLAG(MERR_FLAG),
    .PAR_ERR(PAR_ERR), .DEC_ERR(DEC_ERR));
`default_nettype wire

// *** src/tcw_bank.v ***
// One 36-bit RAM bank: four data bytes plus four ECC bits per word.
// Assumes synchronous write and registered read on CLK.
`timescale 1ns/10ps
`default_nettype none
module tcw_bank #(
    parameter AW = 12,
    parameter W = 36
) (
    input wire clk, // Clock
    input wire cs, // Chip select
    input wire we, // Write enable
    input wire [AW-1:0] addr, // Word address
    input wire [W-1:0] wdata, // Write word
    output reg [W-1:0] rdata // Read word
);
    reg [W-1:0] mem [0:(1<<AW)-1];
    always @(posedge clk) begin
        if (cs) begin
            if (we) begin
                mem[addr] <= wdata;
            end
            rdata <= mem[addr];
        end
    end
endmodule // tcw_bank
`default_nettype wire

// *** src/tcw_wrapper.v ***
// Wrapper between the CPU data tightly coupled port and on-chip RAM.
// Assumes the CPU drives requests on CLK and reads data two cycles later.
`timescale 1ns/10ps
`default_nettype none
`include "tcw_regs.vh"
module tcw_wrapper #(
    parameter AW = `TCW_ADDR_W
) (
    input wire CLK, // 20 MHz clock
    input wire RST, // Sync reset, active high
    input wire REQ, // Access request
    input wire WR, // 1 write, 0 read
    input wire [AW-1:0] ADDR, // Word address
    input wire ADDR_PAR, // Even parity over ADDR
    input wire [7:0] BYTE_EN, // Byte enables
    input wire [63:0] WDATA, // Write data
    input wire [7:0] WECC, // Write ECC
    input wire [1:0] EVENT, // CPU event bus ECC bits
    input wire INIT_START, // Start auto-initialization
    output reg [63:0] RDATA, // Read data
    output reg [7:0] RECC, // Read ECC
    output reg RVALID, // Read data valid
    output reg BUSY, // Initialization running
    output reg INIT_DONE, // Initialization finished
    output reg SERR_IRQ, // Single-bit error interrupt
    output reg MERR_IRQ, // Multibit error interrupt
    output reg [AW-1:0] SERR_ADDR, // Address of single-bit error
    output reg [AW-1:0] MERR_ADDR, // Address of multibit error
    output reg SERR_FLAG, // Single-bit error seen
    output reg MERR_FLAG, // Multibit error seen
    input wire SERR_CLR, // Clear single-bit status
    input wire MERR_CLR, // Clear multibit status
    output reg PAR_ERR, // Address parity error pulse
    output reg DEC_ERR // Redundant decode error pulse
);
    // ----------------------------------------
    // Initialization engine
    // ----------------------------------------
    localparam ST_IDLE = 2'b01;
    localparam ST_INIT = 2'b10;
    reg [1:0] state_q;
    reg [AW-1:0] icnt_q;
    wire init_act = state_q[1];
    always @(posedge CLK) begin
        if (RST) begin
            state_q <= ST_IDLE;
            icnt_q <= {AW{1'b0}};
            BUSY <= 1'b0;
            INIT_DONE <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (INIT_START) begin
                        state_q <= ST_INIT;
                        icnt_q <= {AW{1'b0}};
                        BUSY <= 1'b1;
                        INIT_DONE <= 1'b0;
                    end
                end
                ST_INIT: begin
                    icnt_q <= icnt_q + 1'b1;
                    if (&icnt_q) begin
                        state_q <= ST_IDLE;
                        BUSY <= 1'b0;
                        INIT_DONE <= 1'b1;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
    // ----------------------------------------
    // Access mux
    // ----------------------------------------
    wire cpu_go = REQ & ~init_act;
    wire any_be = |BYTE_EN;
    wire cpu_rd = cpu_go & ~WR;
    wire cpu_wr = cpu_go & WR & any_be;
    wire [63:0] wd = init_act ? 64'h0000_0000_0000_0000 : WDATA;
    wire [7:0] we_ecc = init_act ? `TCW_INIT_ECC : WECC;
    wire par_mis = cpu_go & (^{ADDR, ADDR_PAR});

    // ----------------------------------------
    // Per-bank controls, decoded twice
    // ----------------------------------------
    // Primary decode from active-high terms, shadow from active-low
    // terms, so a stuck select or bank address node shows as a mismatch.
    // The ECC nibble rides in each bank word: chip select is ECC select.
    wire [1:0] cs_p;
    wire [1:0] we_p;
    wire [1:0] cs_n;
    wire [1:0] we_n;
    wire [2*AW-1:0] ba_p;
    wire [2*AW-1:0] ba_s;
    wire [1:0] bank_mis;
    genvar b;
    genvar i;
    generate
        for (b = 0; b < 2; b = b + 1) begin : g_ctl
            // Primary selects and address of bank b
            assign cs_p[b] = init_act | cpu_rd | cpu_wr;
            assign we_p[b] = init_act | cpu_wr;
            assign ba_p[b*AW +: AW] = init_act ? icnt_q : ADDR;
            // Shadow selects, active low, from the raw inputs
            assign cs_n[b] = ~init_act & (~REQ | (WR & ~any_be));
            assign we_n[b] = ~init_act & (~REQ | ~WR | ~any_be);
            assign ba_s[b*AW +: AW] = (ADDR & {AW{~init_act}})
                | (icnt_q & {AW{init_act}});
            assign bank_mis[b] = (cs_p[b] ^ ~cs_n[b])
                | (we_p[b] ^ ~we_n[b])
                | (|(ba_p[b*AW +: AW] ^ ba_s[b*AW +: AW]));
        end
    endgenerate
    wire dec_mis = |bank_mis;

    // ----------------------------------------
    // Interleaved banks
    // ----------------------------------------
    // Bank b holds bytes b, b+2, b+4, b+6 and ECC nibble b
    wire [71:0] wb;
    wire [71:0] rb;
    wire [63:0] rdat;
    generate
        for (b = 0; b < 2; b = b + 1) begin : g_bank
            for (i = 0; i < 4; i = i + 1) begin : g_byte
                assign wb[36*b+8*i +: 8] = wd[16*i+8*b +: 8];
                assign rdat[16*i+8*b +: 8] = rb[36*b+8*i +: 8];
            end
            assign wb[36*b+32 +: 4] = we_ecc[4*b +: 4];
            tcw_bank #(.AW(AW), .W(`TCW_BANK_W)) u_bank (
                .clk(CLK),
                .cs(cs_p[b]),
                .we(we_p[b]),
                .addr(ba_p[b*AW +: AW]),
                .wdata(wb[36*b +: 36]),
                .rdata(rb[36*b +: 36])
            );
        end
    endgenerate

    // ----------------------------------------
    // Read return
    // ----------------------------------------
    reg rd_q;
    reg [AW-1:0] ra_q;
    always @(posedge CLK) begin
        if (RST) begin
            rd_q <= 1'b0;
            ra_q <= {AW{1'b0}};
            RVALID <= 1'b0;
            RDATA <= 64'h0000_0000_0000_0000;
            RECC <= 8'h00;
        end else begin
            rd_q <= cpu_go & ~WR;
            if (cpu_rd) begin
                ra_q <= ADDR;
            end
            RVALID <= 1'b0;
            if (rd_q) begin
                RVALID <= 1'b1;
                RDATA <= rdat;
                RECC <= {rb[71:68], rb[35:32]};
            end
        end
    end
    // ----------------------------------------
    // Error events and capture
    // ----------------------------------------
    // Events refer to the last read; needs CPU-side enable
    reg [AW-1:0] last_a_q;
    always @(posedge CLK) begin
        if (RST) begin
            last_a_q <= {AW{1'b0}};
            SERR_ADDR <= {AW{1'b0}};
            MERR_ADDR <= {AW{1'b0}};
            SERR_FLAG <= 1'b0;
            MERR_FLAG <= 1'b0;
            SERR_IRQ <= 1'b0;
            MERR_IRQ <= 1'b0;
            PAR_ERR <= 1'b0;
            DEC_ERR <= 1'b0;
        end else begin
            if (rd_q) begin
                last_a_q <= ra_q;
            end
            SERR_IRQ <= EVENT[`TCW_EV_SERR];
            MERR_IRQ <= EVENT[`TCW_EV_MERR];
            if (EVENT[`TCW_EV_SERR]) begin
                SERR_ADDR <= last_a_q;
                SERR_FLAG <= 1'b1;
            end else if (SERR_CLR) begin
                SERR_FLAG <= 1'b0;
            end
            if (EVENT[`TCW_EV_MERR]) begin
                MERR_ADDR <= last_a_q;
                MERR_FLAG <= 1'b1;
            end else if (MERR_CLR) begin
                MERR_FLAG <= 1'b0;
            end
            PAR_ERR <= par_mis;
            DEC_ERR <= dec_mis;
        end
    end
endmodule // tcw_wrapper
`default_nettype wire
